// ---- rtl/ats_adc_trigger_sequencer.sv ----
// Trigger selection, channel sequencing and successive approximation
// control of a 10-bit converter, with its APB register file.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module ats_adc_trigger_sequencer
    import ats_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger sources.
    input wire logic ext_trigger_pin,
    input wire logic timer_match_req_0,
    input wire logic timer_match_req_1,
    // Analog front end: channel mux, sample switch, tap and comparator.
    output logic [3:0] analog_sel,
    output logic sample_en,
    output logic [9:0] dac_tap,
    input wire logic cmp_high,
    // Conversion end interrupt, one cycle pulse.
    output logic conv_done_irq
);

    // All state of the block in one record.
    typedef struct packed {
        logic [7:0] first_mode_reg;
        logic [7:0] second_mode_reg;
        logic [7:0] channel_select_reg;
        logic [7:0] compare_mode_reg;
        logic [7:0] compare_threshold_reg;
        logic [15:0][9:0] channel_result_reg;
        ats_state_t state;
        logic [3:0] cur_ch;
        logic [3:0] bit_idx;
        logic [9:0] sar;
        logic [5:0] cnt;
        logic ext_prev;
        logic tmr0_prev;
        logic tmr1_prev;
        logic irq;
        logic [31:0] rdata;
        logic err;
    } ats_regs_t;

    ats_regs_t s_q;
    ats_regs_t s_d;

    // Flags a byte address that hits one of the result registers.
    function automatic logic is_result(input logic [11:0] a);
        is_result = (a >= ATS_OFS_RES0) && (a <= ATS_OFS_RES15) &&
            (a[1:0] == 2'b00);
    endfunction

    // Decodes any address that the bus may touch.
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == ATS_OFS_MODE0) || (a == ATS_OFS_MODE2) ||
            (a == ATS_OFS_CHSEL) || (a == ATS_OFS_PFM) ||
            (a == ATS_OFS_PFT) || is_result(a);
    endfunction

    // Interrupt gate: compare the result byte with the threshold.
    function automatic logic pf_pass(input logic [7:0] pfm,
                                     input logic [7:0] pft,
                                     input logic [9:0] res);
        logic ge;
        ge = (res[9:2] >= pft);
        if (!pfm[ATS_PF_EN]) begin
            pf_pass = 1'b1;
        end else if (pfm[ATS_PF_LESS]) begin
            pf_pass = !ge;
        end else begin
            pf_pass = ge;
        end
    endfunction

    // Decoded configuration fields.
    logic ce;
    logic hw_mode;
    logic [1:0] op_mode;
    logic [1:0] edge_sel;
    logic [1:0] hw_sel;
    logic [3:0] last_ch;
    logic scan;
    logic continuous;

    // Bus qualifiers.
    logic setup_ph;
    logic wr_acc;
    logic cfg_wr;

    // Trigger detection and conversion step results.
    logic ext_rise;
    logic ext_fall;
    logic ext_evt;
    logic tmr_evt;
    logic trig_evt;
    logic [9:0] sar_bit;
    logic [9:0] sar_now;
    logic [3:0] first_ch;
    logic [7:0] wval;

    // Field decode of the stored configuration.
    always_comb begin
        ce = s_q.first_mode_reg[ATS_M0_CE];
        hw_mode = s_q.first_mode_reg[ATS_M0_TMD];
        op_mode = s_q.first_mode_reg[ATS_M0_MD_LO +: 2];
        edge_sel = s_q.first_mode_reg[ATS_M0_ETS_LO +: 2];
        hw_sel = s_q.second_mode_reg[1:0];
        last_ch = s_q.channel_select_reg[3:0];
        scan = (op_mode == ATS_MD_CONT_SCAN) ||
            (op_mode == ATS_MD_ONE_SCAN);
        continuous = (op_mode == ATS_MD_CONT_SEL) ||
            (op_mode == ATS_MD_CONT_SCAN);
        // Select modes convert k alone; scans begin at channel 0.
        first_ch = scan ? 4'h0 : last_ch;
    end

    // Bus phase decode; a write takes effect in the access phase.
    always_comb begin
        setup_ph = psel && !penable;
        wr_acc = psel && penable && pwrite;
        cfg_wr = wr_acc && ((paddr == ATS_OFS_MODE0) ||
            (paddr == ATS_OFS_MODE2) || (paddr == ATS_OFS_CHSEL) ||
            (paddr == ATS_OFS_PFM) || (paddr == ATS_OFS_PFT));
        wval = pwdata[7:0];
    end

    // Trigger events; the sources are sampled synchronously.
    always_comb begin
        ext_rise = ext_trigger_pin && !s_q.ext_prev;
        ext_fall = !ext_trigger_pin && s_q.ext_prev;
        case (edge_sel)
            ATS_ETS_RISE: ext_evt = ext_rise;
            ATS_ETS_FALL: ext_evt = ext_fall;
            ATS_ETS_BOTH: ext_evt = ext_rise || ext_fall;
            default: ext_evt = 1'b0;
        endcase
        case (hw_sel)
            ATS_HW_TMR0: tmr_evt = timer_match_req_0 && !s_q.tmr0_prev;
            ATS_HW_TMR1: tmr_evt = timer_match_req_1 && !s_q.tmr1_prev;
            default: tmr_evt = 1'b0;
        endcase
        if (hw_sel == ATS_HW_EXT) begin
            trig_evt = ext_evt;
        end else begin
            trig_evt = tmr_evt;
        end
        trig_evt = trig_evt && ce && hw_mode;
    end

    // Successive approximation step: keep or drop the trial bit.
    always_comb begin
        sar_bit = 10'h001 << s_q.bit_idx;
        if (cmp_high) begin
            sar_now = s_q.sar;
        end else begin
            sar_now = s_q.sar & ~sar_bit;
        end
    end

    // Next state of the whole block.
    always_comb begin
        s_d = s_q;
        s_d.irq = 1'b0;
        s_d.ext_prev = ext_trigger_pin;
        s_d.tmr0_prev = timer_match_req_0;
        s_d.tmr1_prev = timer_match_req_1;

        // Read data and error are captured in the setup cycle.
        if (setup_ph) begin
            s_d.err = !is_mapped(paddr);
            s_d.rdata = 32'h0000_0000;
            if (paddr == ATS_OFS_MODE0) begin
                s_d.rdata[7:0] = s_q.first_mode_reg;
                s_d.rdata[ATS_M0_EF] = (s_q.state == ATS_SAMPLE) ||
                    (s_q.state == ATS_CONV);
            end else if (paddr == ATS_OFS_MODE2) begin
                s_d.rdata[7:0] = s_q.second_mode_reg;
            end else if (paddr == ATS_OFS_CHSEL) begin
                s_d.rdata[7:0] = s_q.channel_select_reg;
            end else if (paddr == ATS_OFS_PFM) begin
                s_d.rdata[7:0] = s_q.compare_mode_reg;
            end else if (paddr == ATS_OFS_PFT) begin
                s_d.rdata[7:0] = s_q.compare_threshold_reg;
            end else if (is_result(paddr)) begin
                // Ten bits high in the halfword, top byte as its own view.
                s_d.rdata[15:ATS_RES_SHIFT] =
                    s_q.channel_result_reg[paddr[5:2]];
                s_d.rdata[ATS_RES_BYTE_LO +: 8] =
                    s_q.channel_result_reg[paddr[5:2]][9:2];
            end
        end

        // Register writes; the status flag is not writable.
        if (wr_acc) begin
            case (paddr)
                ATS_OFS_MODE0: s_d.first_mode_reg = wval & ATS_MASK_MODE0;
                ATS_OFS_MODE2: s_d.second_mode_reg = wval & ATS_MASK_MODE2;
                ATS_OFS_CHSEL: s_d.channel_select_reg = wval & ATS_MASK_CHSEL;
                ATS_OFS_PFM: s_d.compare_mode_reg = wval & ATS_MASK_PFM;
                ATS_OFS_PFT: s_d.compare_threshold_reg = wval;
                default: ;
            endcase
        end

        // Sequencer.
        case (s_q.state)
            ATS_IDLE: begin
                s_d.cnt = 6'h00;
            end
            ATS_WAIT: begin
                s_d.cnt = 6'h00;
            end
            ATS_SAMPLE: begin
                if (s_q.cnt == ATS_SAMPLE_LAST) begin
                    s_d.state = ATS_CONV;
                    s_d.bit_idx = 4'd9;
                    s_d.sar = 10'h200;
                    s_d.cnt = 6'h00;
                end else begin
                    s_d.cnt = s_q.cnt + 6'h01;
                end
            end
            ATS_CONV: begin
                if (s_q.bit_idx != 4'd0) begin
                    // Keep this bit as decided, try the next one.
                    s_d.sar = sar_now | (sar_bit >> 1);
                    s_d.bit_idx = s_q.bit_idx - 4'd1;
                end else begin
                    // Last bit decided: store and move on.
                    s_d.channel_result_reg[s_q.cur_ch] = sar_now;
                    if (scan && (s_q.cur_ch != last_ch)) begin
                        // Compare mode in a scan judges channel 0 only.
                        if (s_q.cur_ch == 4'h0 &&
                            s_q.compare_mode_reg[ATS_PF_EN]) begin
                            s_d.irq = pf_pass(s_q.compare_mode_reg,
                                s_q.compare_threshold_reg, sar_now);
                        end
                        s_d.cur_ch = s_q.cur_ch + 4'h1;
                        s_d.state = ATS_SAMPLE;
                    end else begin
                        // End of the pass: select or last scan channel.
                        if (!s_q.compare_mode_reg[ATS_PF_EN]) begin
                            s_d.irq = 1'b1;
                        end else if (!scan || last_ch == 4'h0) begin
                            s_d.irq = pf_pass(s_q.compare_mode_reg,
                                s_q.compare_threshold_reg, sar_now);
                        end
                        if (hw_mode) begin
                            s_d.state = ATS_WAIT;
                        end else if (continuous) begin
                            s_d.cur_ch = first_ch;
                            s_d.state = ATS_SAMPLE;
                        end else begin
                            s_d.state = ATS_IDLE;
                        end
                    end
                end
            end
            default: begin
                s_d.state = ATS_IDLE;
            end
        endcase

        // A hardware trigger starts or restarts a pass from the top.
        if (trig_evt && s_q.state != ATS_IDLE) begin
            s_d.state = ATS_SAMPLE;
            s_d.cur_ch = first_ch;
            s_d.cnt = 6'h00;
        end

        // Configuration writes override the sequencer this cycle.
        if (cfg_wr) begin
            if (!s_d.first_mode_reg[ATS_M0_CE]) begin
                // Results are left as they were.
                s_d.state = ATS_IDLE;
            end else if (s_d.first_mode_reg[ATS_M0_TMD]) begin
                // Hardware modes fall back to the trigger wait.
                if (!ce || s_q.state != ATS_WAIT || !trig_evt) begin
                    s_d.state = ATS_WAIT;
                end
            end else if (!ce || s_q.state == ATS_SAMPLE ||
                         s_q.state == ATS_CONV || hw_mode) begin
                // Software mode starts, or restarts a running pass.
                s_d.state = ATS_SAMPLE;
                s_d.cur_ch = (s_d.first_mode_reg[ATS_M0_MD_LO] ?
                    4'h0 : s_d.channel_select_reg[3:0]);
                s_d.cnt = 6'h00;
            end
        end
    end

    // One register stage for all state.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.first_mode_reg <= ATS_RST_REG;
            s_q.second_mode_reg <= ATS_RST_REG;
            s_q.channel_select_reg <= ATS_RST_REG;
            s_q.compare_mode_reg <= ATS_RST_REG;
            s_q.compare_threshold_reg <= ATS_RST_REG;
            s_q.state <= ATS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs. The slave never inserts wait states.
    always_comb begin
        prdata = s_q.rdata;
        pready = 1'b1;
        pslverr = psel && penable && s_q.err;
        analog_sel = s_q.cur_ch;
        sample_en = (s_q.state == ATS_SAMPLE);
        dac_tap = s_q.sar;
        conv_done_irq = s_q.irq;
    end

endmodule

// ---- rtl/ats_pkg.sv ----
// Constants, state codes and register layout of the conversion sequencer.
//
// Summary of operation
// - One bit picks software or hardware start.
// - Two-bit field picks pin, timer 0, timer 1.
// - Software enable starts conversion; store, interrupt.
// - Continuous repeats until enable cleared; one-shot stops.
// - Active flag sets when any conversion starts.
// - Software mode: config write restarts running conversion.
// - Pin trigger edge: rising, falling or both.
// - Hardware modes: enable only arms the converter.
// - Hardware modes: store, interrupt, then await trigger.
// - Active flag cleared while awaiting hardware trigger.
// - Trigger during conversion restarts it from start.
// - Pin mode: config write returns to trigger wait.
// - Timer mode starts on rising edge of match.
// - Timer mode: config write stops, awaits trigger.
// - Four operation modes from two-bit field.
// - Continuous select: repeat one channel, interrupt each.
// - Continuous scan: 0 to k, interrupt after last.
// - One-shot select: convert once, interrupt, stop.
// - One-shot scan: 0 to k once, interrupt, stop.
// - Channel field k; upper four bits read zero.
// - Result in upper ten bits; byte view too.
// - Compare gating of interrupt when compare enabled.
package ats_pkg;

    // Register byte addresses on the APB.
    localparam logic [11:0] ATS_OFS_MODE0 = 12'h000;
    localparam logic [11:0] ATS_OFS_MODE2 = 12'h004;
    localparam logic [11:0] ATS_OFS_CHSEL = 12'h008;
    localparam logic [11:0] ATS_OFS_PFM = 12'h00C;
    localparam logic [11:0] ATS_OFS_PFT = 12'h010;
    localparam logic [11:0] ATS_OFS_RES0 = 12'h040;
    localparam logic [11:0] ATS_OFS_RES15 = 12'h07C;

    // Field positions in the first mode register.
    localparam int ATS_M0_CE = 7;
    localparam int ATS_M0_EF = 6;
    localparam int ATS_M0_ETS_LO = 4;
    localparam int ATS_M0_MD_LO = 2;
    localparam int ATS_M0_TMD = 0;
    // Field positions in the compare mode register.
    localparam int ATS_PF_EN = 7;
    localparam int ATS_PF_LESS = 6;
    // Result field placement in the read word.
    localparam int ATS_RES_SHIFT = 6;
    localparam int ATS_RES_BYTE_LO = 16;

    // Reset values of the writable registers.
    localparam logic [7:0] ATS_RST_REG = 8'h00;

    // Writable bit masks of each register but the threshold, which takes all eight bits.
    localparam logic [7:0] ATS_MASK_MODE0 = 8'hBD;
    localparam logic [7:0] ATS_MASK_MODE2 = 8'h03;
    localparam logic [7:0] ATS_MASK_CHSEL = 8'h0F;
    localparam logic [7:0] ATS_MASK_PFM = 8'hC0;

    // Operation mode codes.
    localparam logic [1:0] ATS_MD_CONT_SEL = 2'h0;
    localparam logic [1:0] ATS_MD_CONT_SCAN = 2'h1;
    localparam logic [1:0] ATS_MD_ONE_SEL = 2'h2;
    localparam logic [1:0] ATS_MD_ONE_SCAN = 2'h3;
    // Hardware trigger source codes.
    localparam logic [1:0] ATS_HW_EXT = 2'h0;
    localparam logic [1:0] ATS_HW_TMR0 = 2'h2;
    localparam logic [1:0] ATS_HW_TMR1 = 2'h3;
    // Pin edge select codes.
    localparam logic [1:0] ATS_ETS_NONE = 2'h0;
    localparam logic [1:0] ATS_ETS_FALL = 2'h1;
    localparam logic [1:0] ATS_ETS_RISE = 2'h2;
    localparam logic [1:0] ATS_ETS_BOTH = 2'h3;

    // Sample time and the cycles it takes at 20 MHz.
    localparam int ATS_CLK_HZ = 20_000_000;
    localparam int ATS_SAMPLE_NS = 1000;
    localparam int ATS_SAMPLE_CYC =
        (ATS_SAMPLE_NS * (ATS_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [5:0] ATS_SAMPLE_LAST = 6'(ATS_SAMPLE_CYC - 1);

    // Sequencer states.
    typedef enum logic [1:0] {
        ATS_IDLE = 2'b00,
        ATS_WAIT = 2'b01,
        ATS_SAMPLE = 2'b10,
        ATS_CONV = 2'b11
    } ats_state_t;

endpackage

// ---- sim/ats_analog_model.sv ----
// Analog front end model: fixed input levels and a comparator.
`timescale 1ns/1ps
module ats_analog_model (
    // Converter side.
    input wire logic [3:0] analog_sel,
    input wire logic [9:0] dac_tap,
    output logic cmp_high
);
    // Each input sits at its own level, so a wrong channel shows up.
    logic [9:0] level;

    // The comparator follows the tap at once, as the real one would.
    always_comb begin
        level = 10'h3F0 - 10'(analog_sel) * 10'h035;
        cmp_high = (level >= dac_tap);
    end
endmodule

// ---- sim/ats_adc_trigger_sequencer_properties.sv ----
// Checker for the conversion sequencer, bound to its top module.
`timescale 1ns/1ps
module ats_adc_trigger_sequencer_properties
    import ats_pkg::*;
(
    // Clock and reset.
    input logic clk,
    input logic resetn,
    // Register bus.
    input logic psel, penable, pwrite, pready, pslverr,
    input logic [11:0] paddr,
    input logic [31:0] pwdata, prdata,
    // Converter side.
    input logic [3:0] analog_sel,
    input logic sample_en,
    input logic [9:0] dac_tap,
    input logic conv_done_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Mirrors of the mode and channel registers, taken from bus writes.
    logic [7:0] m0_q;
    logic [3:0] ch_q;
    logic wr;
    assign wr = psel && penable && pwrite && pready;

    // Mirror update; it lands on the same edge as the design's write.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m0_q <= 8'h00;
            ch_q <= 4'h0;
        end else if (wr && paddr == ATS_OFS_MODE0) begin
            m0_q <= pwdata[7:0];
        end else if (wr && paddr == ATS_OFS_CHSEL) begin
            ch_q <= pwdata[3:0];
        end
    end

    irq_pulse_a: assert property (conv_done_irq |=> !conv_done_irq)
        else $error("End interrupt longer than one cycle.");
    conv_time_a: assert property (conv_done_irq |->
        $past(sample_en, 11) && !$past(sample_en, 10) && !$past(sample_en))
        else $error("Sample and compare phases have the wrong length.");
    sar_first_a: assert property (conv_done_irq |->
        $past(dac_tap, 10) == 10'h200)
        else $error("First trial value is not the midpoint.");
    chan_sel_a: assert property (sample_en |->
        (m0_q[2] ? analog_sel <= ch_q : analog_sel == ch_q))
        else $error("Converted channel disagrees with the channel field.");
    halt_a: assert property (!m0_q[7] && !$past(m0_q[7]) |->
        !sample_en && !conv_done_irq)
        else $error("Conversion activity while disabled.");
    arm_only_a: assert property ($rose(m0_q[7]) && m0_q[0] |-> !sample_en)
        else $error("Hardware mode started without a trigger.");
    sw_start_a: assert property ($rose(m0_q[7]) && !m0_q[0] |-> sample_en)
        else $error("Software enable did not start sampling.");
    hw_rewait_a: assert property (conv_done_irq && m0_q[0] |=> !sample_en)
        else $error("Hardware mode did not return to the wait.");
    once_stop_a: assert property (conv_done_irq && !m0_q[0] && m0_q[3]
        |=> !sample_en)
        else $error("One-shot pass did not stop.");
endmodule

bind ats_adc_trigger_sequencer ats_adc_trigger_sequencer_properties chk (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .analog_sel(analog_sel),
    .sample_en(sample_en), .dac_tap(dac_tap), .conv_done_irq(conv_done_irq)
);

// ---- sim/ats_adc_trigger_sequencer_tb.sv ----
// Self-checking testbench of the conversion sequencer.
`timescale 1ns/1ps
module ats_adc_trigger_sequencer_tb;
    import ats_pkg::*;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, err, ext_pin = 0, sample_en, cmp_high, irq;
    logic [1:0] tmr = 0;
    logic [3:0] analog_sel;
    logic [9:0] dac_tap;
    int mismatches = 0, checked = 0, irqs = 0, n0 = 0;
    logic [11:0] regs [7] = '{ATS_OFS_MODE0, ATS_OFS_MODE2, ATS_OFS_CHSEL,
        ATS_OFS_PFM, ATS_OFS_PFT, ATS_OFS_RES0, ATS_OFS_RES15};

    always #25 clk = ~clk;
    // Interrupts are counted off the edge so no race with the register.
    always @(negedge clk) irqs += (irq === 1'b1);

    ats_adc_trigger_sequencer uut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_trigger_pin(ext_pin), .timer_match_req_0(tmr[0]),
        .timer_match_req_1(tmr[1]), .analog_sel(analog_sel),
        .sample_en(sample_en), .dac_tap(dac_tap), .cmp_high(cmp_high),
        .conv_done_irq(irq));
    ats_analog_model far (.analog_sel(analog_sel), .dac_tap(dac_tap),
        .cmp_high(cmp_high));

    task automatic check(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One bus transfer; the request holds until pready is seen high.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // Halting first keeps the channel write from starting a pass.
    task automatic start(input logic [7:0] m0, input logic [3:0] ch);
        xfer(1, ATS_OFS_MODE0, 0);
        xfer(1, ATS_OFS_CHSEL, 32'(ch));
        xfer(1, ATS_OFS_MODE0, 32'(m0));
        n0 = irqs;
    endtask

    task automatic irq_is(input int n);
        check("interrupts", 32'(irqs - n0), 32'(n));
    endtask

    // Expected result word worked out from the input levels.
    task automatic res_is(input int ch);
        logic [9:0] v;
        v = 10'h3F0 - 10'(ch) * 10'h035;
        xfer(0, 12'(ATS_OFS_RES0 + 4 * ch), 0);
        check("result", rd, {8'h00, v[9:2], v, 6'h00});
    endtask

    // Pulse on a timer match line; the rising edge is the event.
    task automatic pulse(input int t);
        @(posedge clk);
        tmr[t] <= 1;
        cyc(2);
        tmr[t] <= 0;
    endtask

    initial begin
        #1_000_000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        cyc(4);
        resetn <= 1;
        foreach (regs[i]) begin
            xfer(0, regs[i], 0);
            check("reset value", rd, 0);
        end
        xfer(0, 12'h020, 0);
        check("unmapped error", 32'(err), 1);
        xfer(1, ATS_OFS_CHSEL, 32'hFF);
        xfer(0, ATS_OFS_CHSEL, 0);
        check("channel field", rd, 32'h0F);
        // One-shot select: active while running, stopped afterwards.
        start(8'h88, 5);
        xfer(0, ATS_OFS_MODE0, 0);
        check("active flag", rd, 32'hC8);
        cyc(40);
        irq_is(1);
        res_is(5);
        xfer(0, ATS_OFS_MODE0, 0);
        check("stopped", rd, 32'h88);
        // One-shot scan of channels 0 to 3, a single interrupt.
        start(8'h8C, 3);
        cyc(150);
        irq_is(1);
        for (int c = 0; c < 4; c++) res_is(c);
        // Continuous select; a threshold write restarts the pass.
        start(8'h80, 2);
        cyc(18);
        xfer(1, ATS_OFS_PFT, 0);
        n0 = irqs;
        cyc(20);
        irq_is(0);
        cyc(75);
        irq_is(3);
        xfer(1, ATS_OFS_MODE0, 0);
        n0 = irqs;
        cyc(70);
        irq_is(0);
        res_is(2);
        // Continuous scan of channels 0 and 1.
        start(8'h84, 1);
        cyc(125);
        irq_is(2);
        // Pin trigger with the falling, rising and both-edge codes.
        xfer(1, ATS_OFS_MODE2, 32'(ATS_HW_EXT));
        for (int e = 1; e < 4; e++) begin
            start(8'h81 | 8'(e << 4), 4);
            cyc(40);
            irq_is(0);
            xfer(0, ATS_OFS_MODE0, 0);
            check("waiting", rd, 32'(8'h81 | 8'(e << 4)));
            @(posedge clk) ext_pin <= 1;
            cyc(40);
            irq_is(e >> 1);
            @(posedge clk) ext_pin <= 0;
            cyc(40);
            irq_is((e >> 1) + (e & 1));
        end
        res_is(4);
        n0 = irqs;
        @(posedge clk) ext_pin <= 1;
        cyc(10);
        ext_pin <= 0;
        cyc(25);
        irq_is(0);
        cyc(15);
        irq_is(1);
        n0 = irqs;
        @(posedge clk) ext_pin <= 1;
        cyc(10);
        xfer(1, ATS_OFS_PFT, 0);
        cyc(40);
        irq_is(0);
        // Timer sources: only the chosen match line starts a conversion.
        for (int t = 0; t < 2; t++) begin
            xfer(1, ATS_OFS_MODE2, 32'(t ? ATS_HW_TMR1 : ATS_HW_TMR0));
            start(8'h81, 6);
            pulse(1 - t);
            cyc(40);
            irq_is(0);
            pulse(t);
            cyc(40);
            irq_is(1);
            pulse(t);
            cyc(10);
            xfer(1, ATS_OFS_PFT, 0);
            cyc(40);
            irq_is(1);
            res_is(6);
        end
        // Compare gate on channel 5: its top byte 8'hB9 sits below 8'hBA.
        xfer(1, ATS_OFS_PFT, 32'h0000_00BA);
        xfer(1, ATS_OFS_PFM, 32'h0000_0080);
        start(8'h88, 5);
        cyc(40);
        irq_is(0);
        res_is(5);
        xfer(1, ATS_OFS_PFM, 32'h0000_00C0);
        start(8'h88, 5);
        cyc(40);
        irq_is(1);
        tally_and_finish();
    end
endmodule
